// >>> core/dddc_core.sv
// command decoder and register update of a dual 12-bit converter
// Functional notes
// - code 0000 stores data to A input
// - code 0010 stores data to B input
// - code 0100 loads A input and output
// - code 0110 loads A, moves B input out
// - code 1000 loads B input and output
// - code 1010 loads B, moves A input out
// - code 1100 loads both channels with data
// - code 1110 moves both inputs to outputs
// - mode bit selects shutdown and termination
// - top bits choose channels to shut down
// - output codes are unsigned 0 to 4095
// - reset clears channel, shutdown and termination registers to zero
// - sixteen bits msb first, falling clock edges
// - unchained: act after 16th bit, else discard
// - chained: delay 16 bits, act on sync rise
// - clear low forces outputs to zero code
module dddc_core
   import dddc_pkg::*;
(
   input  wire logic                           ref_clk,
   input  wire logic                           srst,
   input  wire logic                           link_clk,
   input  wire logic                           frame_sync_n,
   input  wire logic                           serial_in,
   input  wire logic                           chain_enable,
   input  wire logic                           async_clear_n,
   output logic                                chain_out,
   output logic                                chain_out_oe,
   output logic      [dddc_pkg::CODE_BITS-1:0] code_a,
   output logic      [dddc_pkg::CODE_BITS-1:0] code_b,
   output logic      [1:0]                     output_shutdown,
   output dddc_pkg::dddc_term_t                impedance_a,
   output dddc_pkg::dddc_term_t                impedance_b
);
   import dddc_pkg::*;

   //--------------------------------------------------------------
   // link domain: shift, count, delay line
   //--------------------------------------------------------------
   logic [WORD_BITS-1:0] shift_r;
   logic [CNT_BITS-1:0]  bit_cnt_r;
   logic                 done_tgl_r;
   logic                 full_r;
   logic                 load_tgl_r;

   // shift on every falling edge inside a frame, msb first
   // bits past the sixteenth are dropped unless chained
   always_ff @(negedge link_clk or negedge async_clear_n)
   begin
      if (!async_clear_n)
         shift_r <= WORD_ZERO;
      else if (!frame_sync_n && (chain_enable || bit_cnt_r != FRAME_LEN))
         shift_r <= {shift_r[WORD_BITS-2:0], serial_in};
   end

   // count ends with the frame's own sync rise; clear also sets it up
   // full_r marks that sixteen bits have arrived in this frame
   always_ff @(negedge link_clk or posedge frame_sync_n or negedge async_clear_n)
   begin
      if (frame_sync_n || !async_clear_n)
      begin
         bit_cnt_r <= '0;
         full_r    <= 1'b0;
      end
      else if (bit_cnt_r != FRAME_LEN)
      begin
         bit_cnt_r <= bit_cnt_r + CNT_BITS'(1);
         full_r    <= (bit_cnt_r == FRAME_LEN - CNT_BITS'(1));
      end
   end

   // unchained: event toggles at the 16th falling edge
   always_ff @(negedge link_clk or negedge async_clear_n)
   begin
      if (!async_clear_n)
         done_tgl_r <= 1'b0;
      else if (!frame_sync_n && !chain_enable
               && bit_cnt_r == FRAME_LEN - CNT_BITS'(1))
         done_tgl_r <= ~done_tgl_r;
   end

   // chained: event toggles on the sync rise of a full frame
   // full_r is read before its own clear on this same edge
   always_ff @(posedge frame_sync_n or negedge async_clear_n)
   begin
      if (!async_clear_n)
         load_tgl_r <= 1'b0;
      else if (chain_enable && full_r)
         load_tgl_r <= ~load_tgl_r;
   end

   // bit leaving the register is the input delayed 16 clocks
   // pad drives only while chained and selected
   assign chain_out    = shift_r[WORD_BITS-1];
   assign chain_out_oe = chain_enable && !frame_sync_n;

   //--------------------------------------------------------------
   // crossing into ref_clk
   //--------------------------------------------------------------
   logic [2:0] sync_q;
   logic       clear_n_s;
   logic       done_s;
   logic       load_s;
   logic       done_d_r;
   logic       load_d_r;
   logic       word_go;

   // only the clear level and two toggles cross; the word is held still
   dddc_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk      (ref_clk),
      .async_in ({async_clear_n, done_tgl_r, load_tgl_r}),
      .sync_out (sync_q)
   );

   assign {clear_n_s, done_s, load_s} = sync_q;

   // edge detect follows the toggles even in reset
   // a toggle that moved during reset is taken as already seen
   always_ff @(posedge ref_clk)
   begin
      done_d_r <= done_s;
      load_d_r <= load_s;
   end

   // shift_r is quiet once the event is seen: link idles after frame
   // each toggle change is exactly one frame event
   assign word_go = (done_s != done_d_r)
                 || (load_s != load_d_r);

   //--------------------------------------------------------------
   // command decode
   //--------------------------------------------------------------
   logic [CODE_BITS-1:0] in_a_r;
   logic [CODE_BITS-1:0] in_b_r;
   logic [CODE_BITS-1:0] in_a_nxt;
   logic [CODE_BITS-1:0] in_b_nxt;
   logic [CODE_BITS-1:0] out_a_nxt;
   logic [CODE_BITS-1:0] out_b_nxt;
   logic                 upd_a;
   logic                 upd_b;
   logic [1:0]           pd_set;
   logic [CODE_BITS-1:0] data;
   logic [3:0]           ctrl;
   logic                 clear_all;

   // frame fields, named as the host sees them
   logic                 control_bit_top;
   logic                 control_bit_second;
   logic                 channel_select_bit;
   logic                 mode_select_bit;
   logic [1:0]           impedance_select_field;

   assign control_bit_top        = shift_r[CTRL_TOP];
   assign control_bit_second     = shift_r[CTRL_SEC];
   assign channel_select_bit     = shift_r[CHAN_SEL];
   assign mode_select_bit        = shift_r[MODE_SEL];
   assign impedance_select_field = shift_r[IMP_HI:IMP_LO];

   assign data      = shift_r[CODE_BITS-1:0];
   assign ctrl      = {control_bit_top, control_bit_second, channel_select_bit,
                       mode_select_bit};
   // clear reaches the channels through its synchroniser
   assign clear_all = srst || !clear_n_s;

   // default: the frame changes nothing
   always_comb
   begin
      in_a_nxt  = in_a_r;
      in_b_nxt  = in_b_r;
      out_a_nxt = code_a;
      out_b_nxt = code_b;
      upd_a     = 1'b0;
      upd_b     = 1'b0;
      pd_set    = 2'b00;
      if (ctrl[0])
      begin
         // shutdown: channel bit and low data ignored
         // stored codes are left alone while shut down
         unique case (ctrl[3:2])
            2'b01:   pd_set = 2'b01;
            2'b10:   pd_set = 2'b10;
            default: pd_set = 2'b11;
         endcase
      end
      else
      begin
         unique case (ctrl[3:1])
            3'b000: in_a_nxt = data;
            3'b001: in_b_nxt = data;
            3'b010:
            begin
               in_a_nxt  = data;
               out_a_nxt = data;
               upd_a     = 1'b1;
            end
            3'b011:
            begin
               in_a_nxt  = data;
               out_a_nxt = data;
               out_b_nxt = in_b_r;
               upd_a     = 1'b1;
               upd_b     = 1'b1;
            end
            3'b100:
            begin
               in_b_nxt  = data;
               out_b_nxt = data;
               upd_b     = 1'b1;
            end
            3'b101:
            begin
               in_b_nxt  = data;
               out_b_nxt = data;
               out_a_nxt = in_a_r;
               upd_a     = 1'b1;
               upd_b     = 1'b1;
            end
            3'b110:
            begin
               in_a_nxt  = data;
               in_b_nxt  = data;
               out_a_nxt = data;
               out_b_nxt = data;
               upd_a     = 1'b1;
               upd_b     = 1'b1;
            end
            3'b111:
            begin
               out_a_nxt = in_a_r;
               out_b_nxt = in_b_r;
               upd_a     = 1'b1;
               upd_b     = 1'b1;
            end
         endcase
      end
   end

   //--------------------------------------------------------------
   // channel registers
   //--------------------------------------------------------------
   // codes are plain unsigned 0..4095
   // store-only frames touch the input registers alone
   always_ff @(posedge ref_clk)
   begin
      if (clear_all)
      begin
         in_a_r <= CODE_ZERO;
         in_b_r <= CODE_ZERO;
         code_a <= CODE_ZERO;
         code_b <= CODE_ZERO;
      end
      else if (word_go)
      begin
         in_a_r <= in_a_nxt;
         in_b_r <= in_b_nxt;
         code_a <= out_a_nxt;
         code_b <= out_b_nxt;
      end
   end

   //--------------------------------------------------------------
   // shutdown state, one slice per channel
   //--------------------------------------------------------------
   localparam int CHANNELS = 2;

   logic [CHANNELS-1:0] upd;

   assign upd = {upd_b, upd_a};

   // shutdown state kept until that channel's output is written
   // termination is kept too; it only matters while shut down
   for (genvar ch = 0; ch < CHANNELS; ch++)
   begin : g_shut
      logic       shut_r;
      dddc_term_t term_r;

      always_ff @(posedge ref_clk)
      begin
         if (clear_all)
         begin
            shut_r <= 1'b0;
            term_r <= DDDC_TERM_FLOAT;
         end
         else if (word_go)
         begin
            if (pd_set[ch])
            begin
               shut_r <= 1'b1;
               term_r <= dddc_term_t'(impedance_select_field);
            end
            else if (upd[ch])
               shut_r <= 1'b0;
         end
      end
   end

   // outputs gathered from the per-channel slices
   assign output_shutdown = {g_shut[1].shut_r, g_shut[0].shut_r};
   assign impedance_a     = g_shut[0].term_r;
   assign impedance_b     = g_shut[1].term_r;
endmodule : dddc_core

// >>> core/dddc_pkg.sv
// shared constants of the dual converter command decoder
package dddc_pkg;
   localparam int          WORD_BITS  = 16;
   localparam int          CODE_BITS  = 12;
   localparam int          CNT_BITS   = 5;
   localparam int          SYNC_DEPTH = 2;
   // frame field positions
   localparam int          CTRL_TOP   = 15;
   localparam int          CTRL_SEC   = 14;
   localparam int          CHAN_SEL   = 13;
   localparam int          MODE_SEL   = 12;
   localparam int          IMP_HI     = 11;
   localparam int          IMP_LO     = 10;
   localparam int          DATA_HI    = 11;
   // bits per frame as a counter value
   localparam logic [4:0]  FRAME_LEN  = 5'h10;
   localparam logic [11:0] CODE_ZERO  = 12'h000;
   localparam logic [15:0] WORD_ZERO  = 16'h0000;
   // output termination while shut down
   typedef enum logic [1:0] {
      DDDC_TERM_FLOAT  = 2'h0,
      DDDC_TERM_1K     = 2'h1,
      DDDC_TERM_100K   = 2'h2,
      DDDC_TERM_FLOAT2 = 2'h3
   } dddc_term_t;
endpackage : dddc_pkg

// >>> core/dddc_sync.sv
// two flip-flop level synchroniser, one per bit
module dddc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk)
   begin
      meta_r   <= async_in;
      sync_out <= meta_r;
   end
endmodule : dddc_sync

// >>> verification/dddc_chk_assertions.sv
// port checker of the dual converter command decoder
module dddc_chk
   import dddc_pkg::*;
(
   input wire logic                           ref_clk,
   input wire logic                           srst,
   input wire logic                           link_clk,
   input wire logic                           frame_sync_n,
   input wire logic                           serial_in,
   input wire logic                           chain_enable,
   input wire logic                           async_clear_n,
   input wire logic                           chain_out,
   input wire logic                           chain_out_oe,
   input wire logic [dddc_pkg::CODE_BITS-1:0] code_a,
   input wire logic [dddc_pkg::CODE_BITS-1:0] code_b,
   input wire logic [1:0]                     output_shutdown
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------
   // properties
   // ----------
   property p_srst_codes;
      @(posedge ref_clk) srst |=> code_a == CODE_ZERO && code_b == CODE_ZERO;
   endproperty
   a_srst_codes: assert property (p_srst_codes) else $error("codes kept in reset");
   property p_srst_shut;
      @(posedge ref_clk) srst |=> output_shutdown == 2'h0;
   endproperty
   a_srst_shut: assert property (p_srst_shut) else $error("shutdown kept in reset");
   property p_clr;
      @(posedge ref_clk) disable iff (srst)
         !async_clear_n [*5] |-> code_a == CODE_ZERO && code_b == CODE_ZERO;
   endproperty
   a_clr: assert property (p_clr) else $error("clear ignored");
   property p_oe;
      @(posedge ref_clk) disable iff (srst) chain_out_oe == (chain_enable && !frame_sync_n);
   endproperty
   a_oe: assert property (p_oe) else $error("chain drive wrong");
   property p_quiet;
      @(posedge ref_clk) disable iff (srst) (frame_sync_n && async_clear_n) [*6]
         |=> $stable(code_a) && $stable(code_b) && $stable(output_shutdown);
   endproperty
   a_quiet: assert property (p_quiet) else $error("update without frame");
   property p_chain;
      @(negedge link_clk) disable iff (srst)
         chain_enable && $past(chain_enable, 16) |-> chain_out == $past(serial_in, 16);
   endproperty
   a_chain: assert property (p_chain) else $error("chain delay wrong");
   property p_pd_a;
      @(posedge ref_clk) disable iff (srst) $rose(output_shutdown[0]) |-> $stable(code_a);
   endproperty
   a_pd_a: assert property (p_pd_a) else $error("code a lost");
   property p_pd_b;
      @(posedge ref_clk) disable iff (srst) $rose(output_shutdown[1]) |-> $stable(code_b);
   endproperty
   a_pd_b: assert property (p_pd_b) else $error("code b lost");
   c_shut: cover property (@(posedge ref_clk) $rose(output_shutdown[1]));
   c_chain: cover property (@(posedge ref_clk) chain_out_oe);
   c_clr: cover property (@(posedge ref_clk) !async_clear_n && !srst);
endmodule : dddc_chk

bind dddc_core dddc_chk u_dddc_chk (.ref_clk, .srst, .link_clk, .frame_sync_n, .serial_in,
   .chain_enable, .async_clear_n, .chain_out, .chain_out_oe, .code_a, .code_b, .output_shutdown);

// >>> verification/dddc_host.sv
// host side serial frame driver
module dddc_host (
   output logic link_clk,
   output logic frame_sync_n,
   output logic serial_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      link_clk = 1'b1;
      frame_sync_n = 1'b1;
      serial_in = 1'b0;
   end
   // clock stands high outside frames; data inverted once released
   task send(input logic [31:0] w, input int n);
      frame_sync_n = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         serial_in = w[i];
         #80 link_clk = 1'b0;
         #80 link_clk = 1'b1;
      end
      #80 frame_sync_n = 1'b1;
      serial_in = ~serial_in;
   endtask : send
endmodule : dddc_host

// >>> verification/dual_dac_command_decoder_tb.sv
// self-checking bench of the command decoder
module dual_dac_command_decoder_tb
   import dddc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [15:0] w; logic [23:0] ab; logic [1:0] sd, ia, ib;} dddc_row_t;
   logic        ref_clk = 1'b0;
   logic        srst = 1'b1;
   logic        chain_enable = 1'b0;
   logic        async_clear_n = 1'b1;
   logic        link_clk, frame_sync_n, serial_in, chain_out, chain_out_oe;
   logic [11:0] code_a, code_b;
   logic [1:0]  output_shutdown;
   dddc_term_t  impedance_a, impedance_b;
   int          mismatches = 0;
   int          checks = 0;
   dddc_row_t   rows [17] = '{
      {16'h0123, 24'h000000, 6'h00}, {16'h2456, 24'h000000, 6'h00}, {16'he000, 24'h123456, 6'h00},
      {16'h4789, 24'h789456, 6'h00}, {16'h2abc, 24'h789456, 6'h00}, {16'h6111, 24'h111abc, 6'h00},
      {16'h0222, 24'h111abc, 6'h00}, {16'ha333, 24'h222333, 6'h00}, {16'h8444, 24'h222444, 6'h00},
      {16'hcfff, 24'hffffff, 6'h00}, {16'h5400, 24'hffffff, 6'h14}, {16'h9800, 24'hffffff, 6'h36},
      {16'h0123, 24'hffffff, 6'h36}, {16'h1c00, 24'hffffff, 6'h3f}, {16'h4555, 24'h555fff, 6'h2f},
      {16'hd000, 24'h555fff, 6'h30}, {16'he000, 24'h555fff, 6'h00}};
   always #20 ref_clk = ~ref_clk;
   dddc_core u_dddc_core (.ref_clk, .srst, .link_clk, .frame_sync_n, .serial_in, .chain_enable,
      .async_clear_n, .chain_out, .chain_out_oe, .code_a, .code_b, .output_shutdown,
      .impedance_a, .impedance_b);
   dddc_host u_dddc_host (.link_clk, .frame_sync_n, .serial_in);
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task end_sim;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask : cyc
   task frame(input logic [31:0] w, input int n);
      u_dddc_host.send(w, n);
      cyc(10);
   endtask : frame
   initial
   begin
      #1_000_000;
      mismatches++;
      end_sim;
   end
   initial
   begin
      cyc(1);
      async_clear_n = 1'b0;
      cyc(19);
      srst = 1'b0;
      async_clear_n = 1'b1;
      cyc(2);
      chk({code_a, code_b}, 24'h0);
      foreach (rows[i])
      begin
         frame(rows[i].w, 16);
         chk({code_a, code_b}, rows[i].ab);
         chk(output_shutdown, rows[i].sd);
         if (rows[i].sd[0]) chk(impedance_a, rows[i].ia);
         if (rows[i].sd[1]) chk(impedance_b, rows[i].ib);
      end
      $display("command table done");
      frame(32'h4aaa, 15);
      chk({code_a, code_b}, 24'h555fff);
      frame(32'h9999, 17);
      chk({code_a, code_b}, 24'hcccfff);
      $display("short frame done");
      chain_enable = 1'b1;
      frame(32'h1234_4abc, 32);
      chk({code_a, code_b}, 24'habcfff);
      chain_enable = 1'b0;
      $display("chained frame done");
      async_clear_n = 1'b0;
      cyc(6);
      chk({code_a, code_b}, 24'h0);
      async_clear_n = 1'b1;
      cyc(4);
      $display("clear done");
      frame(32'hcfff, 16);
      srst = 1'b1;
      cyc(3);
      srst = 1'b0;
      cyc(1);
      chk({code_a, code_b, output_shutdown}, 26'h0);
      frame(32'he000, 16);
      chk({code_a, code_b, output_shutdown}, 26'h0);
      $display("reset done");
      end_sim;
   end
endmodule : dual_dac_command_decoder_tb
